// [src/ctp_timer_pair.sv]
// Cascadable timer pair control with Avalon-MM register access.
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ctp_defs.svh"
module ctp_timer_pair
    import ctp_pkg::*;
#(
    parameter int REF_MHZ = 50
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        clkEn,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic        idleMode,
    input  wire logic        genericExternalClockPin,
    input  wire logic        pairedExternalClockPin,
    input  wire logic        lowPowerRcOscillator,
    input  wire logic        secondaryOscillator,
    input  wire logic        lowerGatePin,
    input  wire logic        upperGatePin,
    output logic             lowerIrqFlag,
    output logic             upperIrqFlag,
    output logic             convTrigger
);
    // Refuses a reference clock too slow to make the half-rate tick.
    if (REF_MHZ < 2) begin : gBadClock
        $error("ctp_timer_pair: REF_MHZ too low");
    end
    logic [15:0] lowerCtl_q, upperCtl_q, lowerPer_q, upperPer_q;
    logic [4:0]  syn1_q, syn2_q, synPrev_q;
    logic        half_q;
    logic        lowerFlag_q, upperFlag_q, trig_q;
    logic [31:0] rdata_q;
    ctp_bus_e    bus_q;
    ctp_cfg_s    lowerCfg, upperCfg;
    logic [3:0]  lowerSrc, upperSrc;
    logic [4:0]  rise;
    logic        joined;
    logic        lowerTick, upperTick, lowerWrap, upperWrap, lowerFall, upperFall;
    logic [15:0] lowerCount, upperCount;
    logic        accWr, accRd, wrLowerCtl, wrUpperCtl;
    logic        matchJoined, lowerFlagSet, upperFlagSet;
    logic [15:0] wd16;
    function automatic ctp_cfg_s cfgOf(input logic [15:0] r);
        ctp_cfg_s c;
        c.run      = r[`CTP_BIT_RUN];
        c.idleHalt = r[`CTP_BIT_IDLE];
        c.ecs      = ctp_ecs_e'(r[`CTP_BIT_ECS_HI:`CTP_BIT_ECS_LO]);
        c.gate     = r[`CTP_BIT_GATE];
        c.prescale = r[`CTP_BIT_PS_HI:`CTP_BIT_PS_LO];
        c.srcSel   = r[`CTP_BIT_SRC];
        return c;
    endfunction
    // Pin inputs pass two flip-flops; the half-rate toggle makes Fosc/2.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            syn1_q    <= 5'h00;
            syn2_q    <= 5'h00;
            synPrev_q <= 5'h00;
            half_q    <= 1'b0;
        end else if (clkEn) begin
            syn1_q    <= {upperGatePin, lowerGatePin, lowPowerRcOscillator, pairedExternalClockPin,
                          genericExternalClockPin};
            syn2_q    <= syn1_q;
            synPrev_q <= syn2_q;
            half_q    <= ~half_q;
        end
    end
    assign rise = syn2_q & ~synPrev_q;
    assign joined = lowerCtl_q[`CTP_BIT_JOIN];
    assign lowerCfg = cfgOf(lowerCtl_q);
    assign upperCfg = joined ? lowerCfg : cfgOf(upperCtl_q);
    // Secondary oscillator is ANDed with zero in the low-power RC slot, so it never adds a tick.
    assign lowerSrc = {rise[0], rise[1], rise[2] | (secondaryOscillator & 1'b0), half_q};
    assign upperSrc = {rise[0], rise[1], rise[1], half_q};
    ctp_timer_lane #(.WIDTH(16)) uLower (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .clkEn       (clkEn),
        .cfg         (lowerCfg),
        .idleMode    (idleMode),
        .prescaleClr (wrLowerCtl && lowerCtl_q[`CTP_BIT_RUN]),
        .upperLane   (1'b0),
        .srcTick     (lowerSrc),
        .gateSync    (syn2_q[3]),
        .cntWe       (accWr && address == `CTP_OFF_LCNT),
        .cntWdata    (wd16),
        .period      (joined ? (matchJoined ? lowerPer_q : 16'hFFFF) : lowerPer_q),
        .chainIn     (1'b0),
        .chainMode   (1'b0),
        .tickOut     (lowerTick),
        .wrapOut     (lowerWrap),
        .gateFall    (lowerFall),
        .count       (lowerCount)
    );
    ctp_timer_lane #(.WIDTH(16)) uUpper (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .clkEn       (clkEn),
        .cfg         (upperCfg),
        .idleMode    (idleMode),
        .prescaleClr (wrUpperCtl && upperCtl_q[`CTP_BIT_RUN] && !joined),
        .upperLane   (1'b1),
        .srcTick     (upperSrc),
        .gateSync    (syn2_q[4]),
        .cntWe       (accWr && address == `CTP_OFF_UCNT),
        .cntWdata    (wd16),
        .period      (upperPer_q),
        .chainIn     (lowerTick && (lowerCount == 16'hFFFF || matchJoined)),
        .chainMode   (joined),
        .tickOut     (upperTick),
        .wrapOut     (upperWrap),
        .gateFall    (upperFall),
        .count       (upperCount)
    );
    // Joined match compares both words against the 32-bit period.
    assign matchJoined = ({upperCount, lowerCount} == {upperPer_q, lowerPer_q});
    assign lowerFlagSet = !joined && (lowerWrap || lowerFall);
    assign upperFlagSet = joined ? (lowerTick && matchJoined) || lowerFall
                                 : (upperWrap || upperFall);
    // Bus access decode; a write of writedata low half.
    assign wd16 = writedata[15:0];
    assign accWr = (bus_q == CTP_BUS_ACK) && write && byteenable[1:0] == 2'h3;
    assign accRd = (bus_q == CTP_BUS_ACK) && read;
    assign wrLowerCtl = accWr && address == `CTP_OFF_LCTL;
    assign wrUpperCtl = accWr && address == `CTP_OFF_UCTL;
    assign waitrequest = (bus_q != CTP_BUS_ACK);
    assign readdata = rdata_q;
    // Bus sequencer: one wait cycle, then the answer edge.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_q <= CTP_BUS_IDLE;
        end else if (clkEn) begin
            case (bus_q)
                CTP_BUS_IDLE: bus_q <= (read || write) ? CTP_BUS_ACK : CTP_BUS_IDLE;
                CTP_BUS_ACK:  bus_q <= CTP_BUS_HOLD;
                CTP_BUS_HOLD: bus_q <= CTP_BUS_IDLE;
                default:      bus_q <= CTP_BUS_IDLE;
            endcase
        end
    end
    // Control and period registers; unimplemented bits never store.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lowerCtl_q <= `CTP_CTL_RESET;
            upperCtl_q <= `CTP_CTL_RESET;
            lowerPer_q <= `CTP_PER_RESET;
            upperPer_q <= `CTP_PER_RESET;
        end else if (clkEn) begin
            if (wrLowerCtl) lowerCtl_q <= wd16 & `CTP_LCTL_MASK;
            if (wrUpperCtl) upperCtl_q <= wd16 & `CTP_UCTL_MASK;
            if (accWr && address == `CTP_OFF_LPER) lowerPer_q <= wd16;
            if (accWr && address == `CTP_OFF_UPER) upperPer_q <= wd16;
        end
    end
    // Read data is registered; unmapped offsets read zero.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (clkEn && (bus_q == CTP_BUS_IDLE) && read) begin
            case (address)
                `CTP_OFF_LCTL: rdata_q <= {16'h0000, lowerCtl_q};
                `CTP_OFF_UCTL: rdata_q <= {16'h0000, upperCtl_q};
                `CTP_OFF_LCNT: rdata_q <= {16'h0000, lowerCount};
                `CTP_OFF_UCNT: rdata_q <= {16'h0000, upperCount};
                `CTP_OFF_LPER: rdata_q <= {16'h0000, lowerPer_q};
                `CTP_OFF_UPER: rdata_q <= {16'h0000, upperPer_q};
                `CTP_OFF_STAT: rdata_q <= {29'h0, trig_q, upperFlag_q, lowerFlag_q};
                default:       rdata_q <= 32'h0000_0000;
            endcase
        end
    end
    // Sticky flags: set wins over a software clear (write 1 to clear).
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lowerFlag_q <= 1'b0;
            upperFlag_q <= 1'b0;
            trig_q      <= 1'b0;
        end else if (clkEn) begin
            if (lowerFlagSet) lowerFlag_q <= 1'b1;
            else if (accWr && address == `CTP_OFF_STAT && writedata[0]) lowerFlag_q <= 1'b0;
            if (upperFlagSet) upperFlag_q <= 1'b1;
            else if (accWr && address == `CTP_OFF_STAT && writedata[1]) upperFlag_q <= 1'b0;
            trig_q <= upperFlagSet;
        end
    end
    assign lowerIrqFlag = lowerFlag_q;
    assign upperIrqFlag = upperFlag_q;
    assign convTrigger  = trig_q;
endmodule
`default_nettype wire

// [src/ctp_defs.svh]
// Offsets, field positions, reset values and timing counts of the timer pair.
`ifndef CTP_DEFS_SVH
`define CTP_DEFS_SVH
`define CTP_OFF_LCTL     5'h00
`define CTP_OFF_UCTL     5'h04
`define CTP_OFF_LCNT     5'h08
`define CTP_OFF_UCNT     5'h0C
`define CTP_OFF_LPER     5'h10
`define CTP_OFF_UPER     5'h14
`define CTP_OFF_STAT     5'h18
`define CTP_OFF_MISC     5'h1C
`define CTP_BIT_RUN      15
`define CTP_BIT_IDLE     13
`define CTP_BIT_ECS_HI   9
`define CTP_BIT_ECS_LO   8
`define CTP_BIT_GATE     6
`define CTP_BIT_PS_HI    5
`define CTP_BIT_PS_LO    4
`define CTP_BIT_JOIN     3
`define CTP_BIT_SRC      1
`define CTP_LCTL_MASK    16'hA37A
`define CTP_UCTL_MASK    16'hA372
`define CTP_CTL_RESET    16'h0000
`define CTP_PER_RESET    16'hFFFF
`define CTP_PS_MAX       8'hFF
`endif

// [src/ctp_pkg.sv]
// Types shared by the timer pair control block.
package ctp_pkg;
    typedef enum logic [1:0] {
        CTP_ECS_SECONDARY_OSCILLATOR = 2'h0,
        CTP_ECS_PAIR = 2'h1,
        CTP_ECS_LOW_POWER_RC_OSCILLATOR = 2'h2,
        CTP_ECS_GEN  = 2'h3
    } ctp_ecs_e;
    typedef struct packed {
        logic       run;
        logic       idleHalt;
        ctp_ecs_e   ecs;
        logic       gate;
        logic [1:0] prescale;
        logic       srcSel;
    } ctp_cfg_s;
    typedef enum logic [2:0] {
        CTP_BUS_IDLE = 3'b001,
        CTP_BUS_ACK  = 3'b010,
        CTP_BUS_HOLD = 3'b100
    } ctp_bus_e;
endpackage

// [src/ctp_timer_lane.sv]
// One 16-bit timer lane: clock pick, prescaler, gate and period match.
`timescale 1ns/10ps
`default_nettype none
`include "ctp_defs.svh"
module ctp_timer_lane
    import ctp_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             clkEn,
    input  wire ctp_cfg_s         cfg,
    input  wire logic             idleMode,
    input  wire logic             prescaleClr,
    input  wire logic             upperLane,
    input  wire logic [3:0]       srcTick,
    input  wire logic             gateSync,
    input  wire logic             cntWe,
    input  wire logic [WIDTH-1:0] cntWdata,
    input  wire logic [WIDTH-1:0] period,
    input  wire logic             chainIn,
    input  wire logic             chainMode,
    output logic                  tickOut,
    output logic                  wrapOut,
    output logic                  gateFall,
    output logic [WIDTH-1:0]      count
);
    // Refuses lane widths that the counter logic cannot serve.
    if (WIDTH < 2 || WIDTH > 32) begin : gBadWidth
        $error("ctp_timer_lane: WIDTH out of range");
    end
    logic [7:0] psCnt_q;
    logic       gatePrev_q;
    logic       selTick;
    logic       extSel;
    logic       active;
    logic       preTick;
    logic       gateOn;
    logic [7:0] psLimit;
    // Clock pick: internal half-rate or the extended source.
    always_comb begin
        extSel = cfg.srcSel;
        if (!extSel) begin
            selTick = srcTick[0];
        end else if (upperLane) begin
            selTick = srcTick[2];
        end else begin
            case (cfg.ecs)
                CTP_ECS_GEN:  selTick = srcTick[3];
                CTP_ECS_LOW_POWER_RC_OSCILLATOR: selTick = srcTick[1];
                CTP_ECS_PAIR: selTick = srcTick[2];
                default:      selTick = 1'b0; // Secondary oscillator is not wired, so it never ticks.
            endcase
        end
    end
    assign gateOn  = cfg.gate && !extSel;
    assign active  = cfg.run && !(idleMode && cfg.idleHalt);
    // Prescale ratio limit per field value.
    always_comb begin
        case (cfg.prescale)
            2'h3:    psLimit = 8'hFF;
            2'h2:    psLimit = 8'h3F;
            2'h1:    psLimit = 8'h07;
            default: psLimit = 8'h00;
        endcase
    end
    assign preTick = active && selTick && (!gateOn || gateSync) && (psCnt_q >= psLimit);
    assign tickOut = chainMode ? chainIn : preTick;
    assign wrapOut = tickOut && (count == period);
    assign gateFall = gateOn && active && gatePrev_q && !gateSync;
    // Prescale counter; a control write clears it.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            psCnt_q <= 8'h00;
        end else if (clkEn) begin
            if (prescaleClr || !active) begin
                psCnt_q <= 8'h00;
            end else if (selTick && (!gateOn || gateSync)) begin
                psCnt_q <= (psCnt_q >= psLimit) ? 8'h00 : psCnt_q + 8'h01;
            end
        end
    end
    // Count register: increments per tick, wraps to zero after the period.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count      <= '0;
            gatePrev_q <= 1'b0;
        end else if (clkEn) begin
            gatePrev_q <= gateSync;
            if (cntWe) begin
                count <= cntWdata;
            end else if (tickOut) begin
                count <= (count == period) ? '0 : count + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/ctp_timer_pair_chk.sv]
// Checker of bus handshake, flag stickiness and control read-back.
`timescale 1ns/10ps
`default_nettype none
module ctp_timer_pair_chk (
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        lowerIrqFlag,
    input wire logic        upperIrqFlag,
    input wire logic        convTrigger
);
    // All checks use the reference clock and rest during reset.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Status write-one-to-clear strobes at the answer edge.
    logic clr0;
    logic clr1;
    assign clr0 = write && !waitrequest && address == 5'h18 && writedata[0];
    assign clr1 = write && !waitrequest && address == 5'h18 && writedata[1];
    // Handshake, sticky flags, trigger and reserved bits.
    a_answer_next: assert property ($rose(read || write) |=> !waitrequest)
        else $error("answer not one cycle after request");
    a_wait_idle: assert property (!read && !write |-> waitrequest)
        else $error("waitrequest low with no request");
    a_single_answer: assert property (!waitrequest |=> waitrequest)
        else $error("answer longer than one cycle");
    a_lower_sticky: assert property (lowerIrqFlag && !clr0 |=> lowerIrqFlag)
        else $error("lower flag dropped without clear");
    a_upper_sticky: assert property (upperIrqFlag && !clr1 |=> upperIrqFlag)
        else $error("upper flag dropped without clear");
    a_lower_clear: assert property ($fell(lowerIrqFlag) |-> $past(clr0))
        else $error("lower flag fell without clear");
    a_upper_clear: assert property ($fell(upperIrqFlag) |-> $past(clr1))
        else $error("upper flag fell without clear");
    a_trig_upper: assert property (convTrigger |-> upperIrqFlag)
        else $error("trigger without upper match");
    a_lower_unimp: assert property (read && !waitrequest && address == 5'h00
        |-> (readdata & ~32'h0000A37A) == 32'h0)
        else $error("lower control reserved bit set");
    a_upper_unimp: assert property (read && !waitrequest && address == 5'h04
        |-> (readdata & ~32'h0000A372) == 32'h0)
        else $error("upper control reserved bit set");
endmodule
bind ctp_timer_pair ctp_timer_pair_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .lowerIrqFlag(lowerIrqFlag), .upperIrqFlag(upperIrqFlag), .convTrigger(convTrigger));
`default_nettype wire

// [tb/ctp_timer_pair_tb.sv]
// Self-checking bench of the cascadable timer pair control block.
`timescale 1ns/10ps
`default_nettype none
module ctp_timer_pair_tb;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [4:0]  address = 5'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [3:0]  byteenable = 4'h0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        idleMode = 1'b0;
    logic [3:0]  pins = 4'h0;
    logic        gatePin = 1'b0;
    logic        lowerIrqFlag;
    logic        upperIrqFlag;
    logic        convTrigger;
    logic [31:0] expQ[$];
    int          divs[4] = '{1, 8, 64, 256};
    int          trigCnt = 0;
    int          t0;
    int          mismatches = 0;
    int          n_compared = 0;
    int          seed = 32'h9EBA635A;

    // Clock generator, 20 ns period.
    always #10 ref_clk = ~ref_clk;

    ctp_timer_pair u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .clkEn(1'b1), .address(address),
        .read(read), .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .idleMode(idleMode), .genericExternalClockPin(pins[3]),
        .pairedExternalClockPin(pins[1]), .lowPowerRcOscillator(pins[2]), .secondaryOscillator(pins[0]),
        .lowerGatePin(gatePin), .upperGatePin(1'b0), .lowerIrqFlag(lowerIrqFlag),
        .upperIrqFlag(upperIrqFlag), .convTrigger(convTrigger));

    // Watches answers and trigger pulses, comparing read data with the oldest note.
    always @(posedge ref_clk) begin
        if (convTrigger === 1'b1) begin
            trigCnt++;
        end
        if (reset_n && read && waitrequest === 1'b0) begin
            n_compared++;
            if (expQ.size() == 0 || readdata !== expQ[0]) begin
                mismatches++;
                $display("[FAIL] %0t read at %h gave %h", $time, address, readdata);
            end
            if (expQ.size() > 0) begin
                expQ.delete(0);
            end
        end
    end

    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic c, input string m);
        n_compared++;
        if (c !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    // One bus cycle held until waitrequest is sampled low, then one idle cycle.
    task automatic bus(input logic [4:0] a, input logic w, input logic [15:0] d, input logic [3:0] be);
        int n;
        n = 0;
        address <= a;
        write <= w;
        read <= !w;
        byteenable <= be;
        writedata <= {16'h0, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            mismatches++;
            stop_test();
        end
        read <= 1'b0;
        write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        bus(a, 1'b1, d, 4'h3);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(a, 1'b0, 16'h0, 4'h3);
    endtask

    // Stops a lane, sets period one, zeroes its count and clears both flags.
    task automatic prep(input logic [4:0] ctl);
        wr(ctl, 16'h0);
        wr(ctl + 5'h10, 16'h0001);
        wr(ctl + 5'h08, 16'h0);
        wr(5'h18, 16'h0003);
    endtask

    // Waits a bounded time for a flag and checks the cycle count.
    task automatic wflag(input logic up, input int lo, input int hi);
        int n;
        n = 0;
        while ((up ? upperIrqFlag : lowerIrqFlag) !== 1'b1 && n <= hi) begin
            @(posedge ref_clk);
            n++;
        end
        chk(n >= lo && n <= hi, "flag timing");
    endtask

    // Makes k rising edges with random spacing on one clock pin.
    task automatic pulses(input int idx, input int k);
        repeat (k) begin
            repeat (3 + ($random(seed) & 7)) @(posedge ref_clk);
            pins[idx] <= 1'b1;
            repeat (3 + ($random(seed) & 7)) @(posedge ref_clk);
            pins[idx] <= 1'b0;
        end
    endtask

    // Main sequence.
    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        rd(5'h00, 32'h0);
        rd(5'h04, 32'h0);
        wr(5'h00, 16'h5C85);
        rd(5'h00, 32'h0);
        wr(5'h04, 16'h5C8D);
        rd(5'h04, 32'h0);
        bus(5'h10, 1'b1, 16'h1234, 4'h0);
        rd(5'h10, 32'hFFFF);
        wr(5'h1C, 16'hFFFF);
        rd(5'h1C, 32'h0);
        wr(5'h00, 16'hA37A);
        rd(5'h00, 32'hA37A);
        $display("test registers done");
        idleMode <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            prep(5'h00);
            wr(5'h00, 16'h8300 | 16'(p << 4));
            wflag(1'b0, 4 * divs[p] - 1, 4 * divs[p] + 1);
        end
        // A second control write while running restarts the divide-by-8 prescaler.
        prep(5'h00);
        wr(5'h00, 16'h8310);
        repeat (10) @(posedge ref_clk);
        wr(5'h00, 16'h8310);
        wflag(1'b0, 31, 33);
        prep(5'h00);
        wr(5'h00, 16'hA000);
        repeat (40) @(posedge ref_clk);
        chk(lowerIrqFlag === 1'b0, "counted in idle");
        idleMode <= 1'b0;
        wflag(1'b0, 4, 6);
        $display("test prescale and idle done");
        for (int e = 0; e < 4; e++) begin
            prep(5'h00);
            wr(5'h00, 16'h8042 | 16'(e << 8));
            pulses(e, 3);
            repeat (6) @(posedge ref_clk);
            chk(lowerIrqFlag === (e != 0), "extended source");
        end
        prep(5'h04);
        wr(5'h04, 16'h8002);
        pulses(1, 3);
        repeat (6) @(posedge ref_clk);
        chk(upperIrqFlag === 1'b1 && lowerIrqFlag === 1'b0, "upper pin clock");
        wr(5'h04, 16'h0);
        prep(5'h00);
        wr(5'h10, 16'hFFFF);
        wr(5'h00, 16'h8040);
        gatePin <= 1'b1;
        repeat (10 + ($random(seed) & 15)) @(posedge ref_clk);
        chk(lowerIrqFlag === 1'b0, "early gate flag");
        gatePin <= 1'b0;
        wflag(1'b0, 3, 5);
        $display("test sources and gate done");
        prep(5'h04);
        prep(5'h00);
        wr(5'h00, 16'h0008);
        wr(5'h04, 16'h8030);
        wr(5'h14, 16'h0);
        t0 = trigCnt;
        wr(5'h00, 16'h8008);
        wflag(1'b1, 3, 5);
        wr(5'h00, 16'h0008);
        rd(5'h18, 32'h2);
        chk(trigCnt > t0, "no trigger");
        wr(5'h10, 16'hFFFF);
        wr(5'h14, 16'h0001);
        wr(5'h08, 16'hFFFE);
        wr(5'h0C, 16'h0);
        wr(5'h00, 16'h8008);
        repeat (4) @(posedge ref_clk);
        wr(5'h00, 16'h0008);
        rd(5'h0C, 32'h1);
        $display("test joined mode done");
        stop_test();
    end
endmodule
`default_nettype wire
